// *** design/i2cms_start.sv ***
// Purpose: Baud counter and START generation with bus collision detection for a two-wire master
// Assumes: Pins synchronised by two flops; pin outputs are open-drain enables
// Notes:   Data, acknowledge, repeated start and stop sequencing are outside this block
`timescale 1ns/100ps
module i2cms_start
	import i2cms_pkg::*;
(
	input  wire logic                      core_clk,
	input  wire logic                      sys_rst,
	input  wire logic                      master_mode,
	input  wire logic [7:0]                baud_reload_register,
	input  wire logic                      start_request_set,
	input  wire logic                      bus_collision_clr,
	input  wire logic                      serial_port_irq_clr,
	input  wire logic                      scl_in,
	input  wire logic                      sda_in,
	output logic                           scl_oe,
	output logic                           sda_oe,
	output logic                           scl_out,
	output logic                           sda_out,
	output logic                           start_request_bit,
	output logic                           bus_collision_flag,
	output logic                           serial_port_irq_flag,
	output logic                           start_busy,
	output logic [I2CMS_RELOAD_W-1:0]      baud_counter
);
	// Pin synchronisers: released lines read high, so a reset value of one gives no false low
	// Only the second flop is read by the logic below
	i2cms_pins_t meta_q, meta_d;
	i2cms_pins_t sync_q, sync_d;
	always_comb begin
		meta_d = '{scl: scl_in, sda: sda_in};
		sync_d = meta_q;
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			meta_q <= '1;
			sync_q <= '1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	// Phase divider: one enable per phase, decrement only on second and fourth
	logic [1:0] phase_q, phase_d;
	logic       dec_en;
	always_comb begin
		phase_d = (phase_q == I2CMS_DIV_LAST) ? 2'h0 : phase_q + 2'h1;
	end
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			phase_q <= 2'h0;
		end else begin
			phase_q <= phase_d;
		end
	end
	assign dec_en = (phase_q == I2CMS_PH_Q2) || (phase_q == I2CMS_PH_Q4);

	i2cms_state_t state_q, state_d;
	logic [6:0]   cnt_q, cnt_d;
	logic         sda_low_q, sda_low_d;
	logic         scl_low_q, scl_low_d;
	logic         req_q, req_d;
	logic         bcl_q, bcl_d;
	logic         irq_q, irq_d;
	logic [6:0]   reload;
	logic         cnt_zero;
	logic         cnt_load;
	logic         cnt_clear;
	logic         set_bcl;
	logic         set_irq;

	assign reload   = baud_reload_register[I2CMS_RELOAD_MSB:0];
	assign cnt_zero = (cnt_q == I2CMS_CNT_ZERO);

	// Baud counter: a load beats a clear, a clear beats the down count
	always_comb begin
		cnt_d = cnt_q;
		if (cnt_load) begin
			cnt_d = reload;
		end else if (cnt_clear) begin
			cnt_d = I2CMS_CNT_ZERO;
		end else if (dec_en && !cnt_zero) begin
			// Stops at zero; only a load restarts it
			cnt_d = cnt_q - 7'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			cnt_q <= I2CMS_CNT_ZERO;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// START sequencer: owns the line drives and the counter controls
	always_comb begin
		state_d   = state_q;
		sda_low_d = sda_low_q;
		scl_low_d = scl_low_q;
		cnt_load  = 1'b0;
		cnt_clear = 1'b0;
		set_bcl   = 1'b0;
		set_irq   = 1'b0;
		case (state_q)
			I2CMS_IDLE: begin
				cnt_clear = 1'b1;
				if (req_q && master_mode) begin
					if (!sync_q.sda || !sync_q.scl) begin
						set_bcl = 1'b1;
					end else begin
						cnt_load = 1'b1;
						state_d  = I2CMS_CHECK;
					end
				end
			end
			I2CMS_CHECK: begin
				if (!sync_q.scl && sync_q.sda) begin
					// Another master is driving a one while clock falls
					set_bcl   = 1'b1;
					cnt_clear = 1'b1;
					state_d   = I2CMS_IDLE;
				end else if (!sync_q.sda || cnt_zero) begin
					// Early data low from another master is not a collision
					sda_low_d = 1'b1;
					cnt_load  = 1'b1;
					state_d   = I2CMS_HOLD1;
				end
			end
			I2CMS_HOLD1: begin
				// Clock low here is tolerated; wait at zero until clock is seen high
				if (cnt_zero) begin
					if (sync_q.scl) begin
						scl_low_d = 1'b1;
						cnt_load  = 1'b1;
						state_d   = I2CMS_HOLD2;
					end
				end
			end
			I2CMS_HOLD2: begin
				// Hold time after clock falls before any other bus operation
				if (cnt_zero) begin
					set_irq = 1'b1;
					state_d = I2CMS_DONE;
				end
			end
			I2CMS_DONE: begin
				state_d = I2CMS_IDLE;
			end
			default: begin
				state_d = I2CMS_IDLE;
			end
		endcase
		// A collision releases both lines so the other master keeps the bus
		if (set_bcl) begin
			sda_low_d = 1'b0;
			scl_low_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q   <= I2CMS_IDLE;
			sda_low_q <= 1'b0;
			scl_low_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			sda_low_q <= sda_low_d;
			scl_low_q <= scl_low_d;
		end
	end

	// Request bit: taken only while idle, so a busy START cannot be restarted
	always_comb begin
		req_d = req_q;
		if (set_bcl || set_irq) begin
			req_d = 1'b0;
		end else if (start_request_set && state_q == I2CMS_IDLE) begin
			req_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			req_q <= 1'b0;
		end else begin
			req_q <= req_d;
		end
	end

	// Flags: a hardware set wins over a same-cycle software clear
	always_comb begin
		bcl_d = set_bcl | (bcl_q & ~bus_collision_clr);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			bcl_q <= 1'b0;
		end else begin
			bcl_q <= bcl_d;
		end
	end

	always_comb begin
		irq_d = set_irq | (irq_q & ~serial_port_irq_clr);
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= irq_d;
		end
	end

	// Open drain: drive zero only while enabled; the lines stay driven after START until a collision or reset
	assign sda_oe               = sda_low_q;
	assign scl_oe               = scl_low_q;
	assign sda_out              = 1'b0;
	assign scl_out              = 1'b0;
	assign start_request_bit    = req_q;
	assign bus_collision_flag   = bcl_q;
	assign serial_port_irq_flag = irq_q;
	assign start_busy           = (state_q != I2CMS_IDLE);
	assign baud_counter         = cnt_q;
endmodule

// *** design/i2cms_pkg.sv ***
// Purpose: Shared constants and types for the two-wire master START and baud counter block
// Assumes: One core clock; phase enables derived by a divider
// Notes:   Widths fixed
package i2cms_pkg;
	localparam int unsigned      I2CMS_RELOAD_W  = 7;
	localparam int unsigned      I2CMS_RELOAD_MSB = 6;
	localparam logic [6:0]       I2CMS_CNT_ZERO  = 7'h00;
	// Phases per instruction cycle, one core cycle each; the divider wraps after the last
	localparam int unsigned      I2CMS_PHASE_DIV = 4;
	localparam logic [1:0]       I2CMS_DIV_LAST  = 2'(I2CMS_PHASE_DIV - 1);
	localparam logic [1:0]       I2CMS_PH_Q2     = 2'h1;
	localparam logic [1:0]       I2CMS_PH_Q4     = 2'h3;

	typedef enum logic [2:0] {
		I2CMS_IDLE  = 3'h0,
		I2CMS_CHECK = 3'h1,
		I2CMS_HOLD1 = 3'h3,
		I2CMS_HOLD2 = 3'h2,
		I2CMS_DONE  = 3'h6
	} i2cms_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} i2cms_pins_t;
endpackage

// *** tb/i2cms_bus_model.sv ***
// Purpose: Open-drain bus with pull-ups
// Assumes: Any driver low wins
// Notes:   Released lines read high
`timescale 1ns/100ps
module i2cms_bus_model(
	input  wire logic scl_oe,
	input  wire logic sda_oe,
	input  wire logic ext_scl,
	input  wire logic ext_sda,
	output logic      scl,
	output logic      sda
);
	assign scl = !(scl_oe || ext_scl);
	assign sda = !(sda_oe || ext_sda);
endmodule

// *** tb/i2cms_start_assertions.sv ***
// Purpose: Concurrent checks on START
// Assumes: Reload value stable while busy
// Notes:   Bounds allow for synchronisers
`timescale 1ns/100ps
module i2cms_start_assertions(
	input wire logic       core_clk,
	input wire logic       sys_rst,
	input wire logic [7:0] baud_reload_register,
	input wire logic       scl_oe,
	input wire logic       sda_oe,
	input wire logic       start_busy,
	input wire logic       bus_collision_flag,
	input wire logic       serial_port_irq_flag,
	input wire logic [6:0] baud_counter
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_cnt_reload: assert property ($past(baud_counter) == 7'h00 && baud_counter != 7'h00
		|-> baud_counter == baud_reload_register[6:0]) else $error("bad reload");
	a_cnt_step: assert property ($past(baud_counter) != 7'h00 && $changed(baud_counter)
		&& baud_counter != baud_reload_register[6:0] |-> baud_counter == $past(baud_counter) - 7'h01
		|| baud_counter == 7'h00) else $error("bad step");
	a_cnt_hold: assert property (baud_counter == 7'h00
		|=> baud_counter == 7'h00 || baud_counter == baud_reload_register[6:0]) else $error("bad hold");
	a_coll_idle: assert property ($rose(bus_collision_flag)
		|-> ##[0:2] !start_busy && !scl_oe && !sda_oe) else $error("no abort");
	a_coll_early: assert property ($rose(bus_collision_flag) |-> !$past(sda_oe)) else $error("late");
	a_irq_done: assert property ($rose(serial_port_irq_flag) |-> scl_oe && sda_oe) else $error("irq");
	a_scl_order: assert property ($rose(scl_oe) |-> sda_oe) else $error("order");
	a_sda_hold: assert property ($fell(sda_oe) |-> ##[0:1] bus_collision_flag) else $error("drop");
endmodule
bind i2cms_start i2cms_start_assertions chk_u (.*);

// *** tb/i2cms_start_tb.sv ***
// Purpose: Self-checking START bench
// Assumes: Other master pulls lines low
// Notes:   Reset per run; lines stay driven
`timescale 1ns/100ps
module i2cms_start_tb;
	logic       core_clk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [7:0] rld = 8'h00;
	logic       req = 1'b0;
	logic       clr = 1'b0;
	logic       ext_scl = 1'b0;
	logic       ext_sda = 1'b0;
	logic       mm = 1'b1;
	logic       scl, sda, scl_oe, sda_oe, rqb, coll, irq, busy, scl_drv, sda_drv;
	int         n_fail = 0;
	int         n_tests = 0;
	always #2 core_clk = ~core_clk;
	i2cms_bus_model bus_u(.scl_oe(scl_oe), .sda_oe(sda_oe), .ext_scl(ext_scl), .ext_sda(ext_sda),
		.scl(scl), .sda(sda));
	i2cms_start dut_u(.core_clk(core_clk), .sys_rst(sys_rst), .master_mode(mm), .baud_reload_register(rld),
		.start_request_set(req), .bus_collision_clr(clr), .serial_port_irq_clr(clr), .scl_in(scl),
		.sda_in(sda), .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_out(scl_drv), .sda_out(sda_drv),
		.start_request_bit(rqb),
		.bus_collision_flag(coll), .serial_port_irq_flag(irq), .start_busy(busy), .baud_counter());
	task automatic stop_test;
		if (n_fail == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input int id);
		n_tests++;
		if (ok !== 1'b1) begin
			n_fail++;
			$display("CHECK FAILED %0t case %0d", $time, id);
		end
	endtask
	function automatic logic exp_coll(input int ph, input logic hs, input logic hd);
		return (ph == 0 && (hs || hd)) || (ph == 1 && hs && !hd);
	endfunction
	// Phase 0 holds from reset, 1 after three cycles, 2 one cycle after data is driven, 3 never
	task automatic go(input logic [7:0] r, input int ph, input logic hs, input logic hd);
		int t;
		int ts;
		logic ec;
		ec = mm && exp_coll(ph, hs, hd);
		sys_rst = 1'b1;
		rld = r;
		ext_scl = hs && ph == 0;
		ext_sda = hd && ph == 0;
		repeat (5) @(negedge core_clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge core_clk);
		req = 1'b1;
		@(negedge core_clk);
		req = 1'b0;
		ts = 0;
		for (t = 1; t < 2000 && (busy !== 1'b0 || t < 4); t++) begin
			@(negedge core_clk);
			if (sda_oe === 1'b1 && ts == 0)
				ts = t;
			if ((ph == 1 && t == 3) || (ph == 2 && ts != 0 && t == ts + 1))
				{ext_scl, ext_sda} = {hs, hd};
			if (ph == 2 && ext_scl)
				chk(scl_oe === 1'b0, 5);
			if (t == ts + 40)
				{ext_scl, ext_sda} = 2'b00;
		end
		chk(t < 2000, 0);
		if (t >= 2000)
			stop_test();
		chk(coll === ec && irq === (mm && !ec) && rqb === !mm, 1);
		chk(scl_oe === (mm && !ec) && sda_oe === (mm && !ec) && {scl_drv, sda_drv} === 2'b00, 2);
		if (!mm)
			chk(ts == 0 && busy === 1'b0, 7);
		if (ph == 3 && mm)
			chk(ts >= 2 * r[6:0] - 2 && ts <= 2 * r[6:0] + 10, 3);
		if (ph == 1 && hd)
			chk(ts > 0 && ts < 20, 4);
		clr = 1'b1;
		@(negedge core_clk);
		clr = 1'b0;
		@(negedge core_clk);
		chk(coll === 1'b0 && irq === 1'b0, 6);
	endtask
	initial begin
		void'($urandom(32'he802));
		go(8'h01, 3, 1'b0, 1'b0);
		go(8'hff, 3, 1'b0, 1'b0);
		repeat (4) go(8'($urandom_range(255, 1)) | 8'h01, 3, 1'b0, 1'b0);
		go(8'h10, 0, 1'b1, 1'b0);
		go(8'h10, 0, 1'b0, 1'b1);
		go(8'h14, 1, 1'b1, 1'b0);
		go(8'h64, 1, 1'b0, 1'b1);
		go(8'h18, 1, 1'b1, 1'b1);
		mm = 1'b0;
		go(8'h10, 0, 1'b1, 1'b0);
		mm = 1'b1;
		go(8'h05, 2, 1'b1, 1'b0);
		stop_test();
	end
endmodule
